/* File: include/rhd_defs.svh */
`ifndef RHD_DEFS_SVH
`define RHD_DEFS_SVH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define RHD_IDX_HOUR      6'h04
`define RHD_IDX_HMATCH    6'h05
`define RHD_IDX_WEEKDAY   6'h06
`define RHD_IDX_MONTHDAY  6'h07
`define RHD_IDX_MONTH     6'h08
`define RHD_IDX_YEAR      6'h09
`define RHD_IDX_CTRL      6'h0A
`define RHD_IDX_STAT      6'h0B
`define RHD_NUM_REGS      6
`define RHD_REG_RST       8'h00

// ****************************************************************
// Field positions and codes.
// ****************************************************************
`define RHD_CTRL_DM_BIT    2
`define RHD_CTRL_H24_BIT   1
`define RHD_STAT_MATCH_BIT 0
`define RHD_STAT_REJ_BIT   1
`define RHD_PM_BIT         7
`define RHD_WILDCARD       2'h3
`define RHD_RESP_OKAY      2'h0
`define RHD_RESP_SLVERR    2'h2

// ****************************************************************
// Value ranges, in binary.
// ****************************************************************
`define RHD_HOUR12_MIN    7'h01
`define RHD_HOUR12_MAX    7'h0C
`define RHD_HOUR24_MAX    7'h17
`define RHD_WEEKDAY_MIN   8'h01
`define RHD_WEEKDAY_MAX   8'h07
`define RHD_MDAY_MIN      7'h01
`define RHD_MDAY_MAX      7'h1F
`define RHD_MONTH_MIN     7'h01
`define RHD_MONTH_MAX     7'h0C
`define RHD_YEAR_MAX      7'h63
`define RHD_BCD_RADIX     7'h0A
`define RHD_BCD_DIGIT_MAX 4'h9

`endif

/* File: include/rhd_pkg.sv */
package rhd_pkg;

   typedef logic [1:0] rhd_resp_t;

   typedef struct packed {
      logic                aw_have;
      logic [5:0]          aw_idx;
      logic                w_have;
      logic [7:0]          wdata;
      logic                wlane;
      logic                awready;
      logic                wready;
      logic                bvalid;
      rhd_resp_t           bresp;
      logic                arready;
      logic                rvalid;
      rhd_resp_t           rresp;
      logic [7:0]          rdata;
      logic [5:0][7:0]     regs;
      logic                dm;
      logic                h24;
      logic                match;
      logic                rej;
   } rhd_state_t;

endpackage

/* File: rtl/rhd_bcd_dec.sv */
`timescale 1ns/1ns
`include "rhd_defs.svh"

// ****************************************************************
// Decodes a written byte to binary in the selected format.
// ****************************************************************
module rhd_bcd_dec (
   input  wire logic [7:0] raw,
   input  wire logic       bcd,
   output logic      [6:0] bin,
   output logic            ok
);
   logic [3:0] hi;
   logic [3:0] lo;

   assign hi  = raw[7:4];
   assign lo  = raw[3:0];
   assign bin = bcd ? 7'(7'(hi) * `RHD_BCD_RADIX + 7'(lo)) : raw[6:0];
   assign ok  = bcd ? (hi <= `RHD_BCD_DIGIT_MAX && lo <= `RHD_BCD_DIGIT_MAX)
                    : !raw[7];
endmodule // rhd_bcd_dec

/* File: rtl/rhd_regs.sv */
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "rhd_defs.svh"

// Behaviour
// - In 12-hour mode, hour bit 7 is the PM flag, 1 afternoon.
// - Hour bits 6:0 hold 1 to 12, or 0 to 23 in 24-hour mode.
// - Hour and date counts are binary or packed BCD, per data-mode bit.
// - Hour-match is compared with hour and feeds the alarm event.
// - Hour-match with both top bits set always matches.
// - Weekday counts 1, Sunday, through 7, Saturday.
// - Weekday encoding ignores the data-mode bit.
// - Monthday_count stays within 1 to 31.
// - Month stays within 1 to 12.
// - Year stays within 0 to 99, meaning 2000 to 2099.
// - Data-mode bit 1 selects binary, 0 selects BCD.
// - Hour-format bit 1 selects 24-hour with PM clear, 0 12-hour.
module rhd_regs (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output rhd_pkg::rhd_resp_t     s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output rhd_pkg::rhd_resp_t     s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic                   hour_alarm_match,
   output logic                   data_format_select,
   output logic                   hour_format_24
);
   import rhd_pkg::*;

   rhd_state_t s;
   rhd_state_t next_s;
   logic       commit;
   logic       is_hour;
   logic [7:0] dec_in;
   logic [6:0] dec_bin;
   logic       dec_ok;
   logic       val_ok;
   logic [5:0] ar_idx;
   logic [2:0] w_slot;

   // ****************************************************************
   // Write value decode.
   // ****************************************************************
   assign commit  = s.aw_have && s.w_have && !s.bvalid;
   assign is_hour = s.aw_idx == `RHD_IDX_HOUR ||
                    s.aw_idx == `RHD_IDX_HMATCH;
   assign dec_in  = is_hour ? {1'b0, s.wdata[6:0]} : s.wdata;
   assign ar_idx  = s_axi_araddr[7:2];
   assign w_slot  = 3'(s.aw_idx - `RHD_IDX_HOUR);

   rhd_bcd_dec u_dec (
      .raw (dec_in),
      .bcd (!s.dm),
      .bin (dec_bin),
      .ok  (dec_ok)
   );

   function automatic logic hour_ok(input logic [7:0] raw,
                                    input logic [6:0] bin,
                                    input logic       h24);
      if (h24) begin
         hour_ok = !raw[`RHD_PM_BIT] && bin <= `RHD_HOUR24_MAX;
      end else begin
         hour_ok = bin >= `RHD_HOUR12_MIN &&
                   bin <= `RHD_HOUR12_MAX;
      end
   endfunction

   always_comb begin
      val_ok = 1'b0;
      unique case (s.aw_idx)
         `RHD_IDX_HOUR: begin
            val_ok = dec_ok && hour_ok(s.wdata, dec_bin, s.h24);
         end
         `RHD_IDX_HMATCH: begin
            val_ok = s.wdata[7:6] == `RHD_WILDCARD ||
                     (dec_ok && hour_ok(s.wdata, dec_bin, s.h24));
         end
         `RHD_IDX_WEEKDAY: begin
            val_ok = s.wdata >= `RHD_WEEKDAY_MIN &&
                     s.wdata <= `RHD_WEEKDAY_MAX;
         end
         `RHD_IDX_MONTHDAY: begin
            val_ok = dec_ok && dec_bin >= `RHD_MDAY_MIN &&
                     dec_bin <= `RHD_MDAY_MAX;
         end
         `RHD_IDX_MONTH: begin
            val_ok = dec_ok && dec_bin >= `RHD_MONTH_MIN &&
                     dec_bin <= `RHD_MONTH_MAX;
         end
         `RHD_IDX_YEAR: begin
            val_ok = dec_ok && dec_bin <= `RHD_YEAR_MAX;
         end
         default: begin
            val_ok = 1'b0;
         end
      endcase
   end

   // ****************************************************************
   // State update.
   // ****************************************************************
   always_comb begin
      next_s = s;
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
      if (s_axi_awvalid && s.awready) begin
         next_s.aw_have = 1'b1;
         next_s.aw_idx  = s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s.wready) begin
         next_s.w_have = 1'b1;
         next_s.wdata  = s_axi_wdata[7:0];
         next_s.wlane  = s_axi_wstrb[0];
      end
      if (commit) begin
         next_s.aw_have = 1'b0;
         next_s.w_have  = 1'b0;
         next_s.bvalid  = 1'b1;
         next_s.bresp   = `RHD_RESP_OKAY;
         if (s.aw_idx >= `RHD_IDX_HOUR && s.aw_idx <= `RHD_IDX_YEAR) begin
            if (s.wlane) begin
               next_s.rej = !val_ok;
               if (val_ok) begin
                  next_s.regs[w_slot] = s.wdata;
               end
            end
         end else if (s.aw_idx == `RHD_IDX_CTRL) begin
            if (s.wlane) begin
               next_s.dm  = s.wdata[`RHD_CTRL_DM_BIT];
               next_s.h24 = s.wdata[`RHD_CTRL_H24_BIT];
               if (s.wdata[`RHD_CTRL_H24_BIT]) begin
                  next_s.regs[0][`RHD_PM_BIT] = 1'b0;
                  if (s.regs[1][7:6] != `RHD_WILDCARD) begin
                     next_s.regs[1][`RHD_PM_BIT] = 1'b0;
                  end
               end
            end
         end else if (s.aw_idx != `RHD_IDX_STAT) begin
            next_s.bresp = `RHD_RESP_SLVERR;
         end
      end
      if (s_axi_arvalid && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = `RHD_RESP_OKAY;
         next_s.rdata  = `RHD_REG_RST;
         if (ar_idx >= `RHD_IDX_HOUR && ar_idx <= `RHD_IDX_YEAR) begin
            next_s.rdata = s.regs[3'(ar_idx - `RHD_IDX_HOUR)];
         end else if (ar_idx == `RHD_IDX_CTRL) begin
            next_s.rdata[`RHD_CTRL_DM_BIT]  = s.dm;
            next_s.rdata[`RHD_CTRL_H24_BIT] = s.h24;
         end else if (ar_idx == `RHD_IDX_STAT) begin
            next_s.rdata[`RHD_STAT_MATCH_BIT] = s.match;
            next_s.rdata[`RHD_STAT_REJ_BIT]   = s.rej;
         end else begin
            next_s.rresp = `RHD_RESP_SLVERR;
         end
      end
      next_s.awready = !next_s.aw_have && !next_s.bvalid;
      next_s.wready  = !next_s.w_have && !next_s.bvalid;
      next_s.arready = !next_s.rvalid;
      next_s.match   = next_s.regs[1][7:6] == `RHD_WILDCARD ||
                       next_s.regs[1] == next_s.regs[0];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s       <= '0;
         s.match <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ****************************************************************
   // Outputs.
   // ****************************************************************
   assign s_axi_awready      = s.awready;
   assign s_axi_wready       = s.wready;
   assign s_axi_bvalid       = s.bvalid;
   assign s_axi_bresp        = s.bresp;
   assign s_axi_arready      = s.arready;
   assign s_axi_rvalid       = s.rvalid;
   assign s_axi_rresp        = s.rresp;
   assign s_axi_rdata        = {24'h00_0000, s.rdata};
   assign hour_alarm_match   = s.match;
   assign data_format_select = s.dm;
   assign hour_format_24     = s.h24;

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence wr_hour_s;
      commit && s.wlane && s.aw_idx == `RHD_IDX_HOUR;
   endsequence

   sequence wr_slot_s(logic [5:0] idx);
      commit && s.wlane && s.aw_idx == idx;
   endsequence

   sequence aw_w_taken_s;
      s_axi_awvalid && s.awready && s_axi_wvalid && s.wready;
   endsequence

   write_resp_a: assert property (aw_w_taken_s |-> ##2 s.bvalid)
      else $error("Write response late.");

   pm_clear_a: assert property (
      s.h24 |-> !s.regs[0][`RHD_PM_BIT])
      else $error("PM flag set in 24-hour mode.");

   pm_flag_a: assert property (
      wr_hour_s ##0 (!s.h24 && !s.dm && s.wdata == 8'h92)
      |=> s.regs[0][`RHD_PM_BIT] && s.regs[0][6:0] == 7'h12)
      else $error("PM hour not stored.");

   hour_range_a: assert property (
      wr_hour_s ##0 (s.dm && s.h24 && s.wdata[6:0] > `RHD_HOUR24_MAX)
      |=> $stable(s.regs[0]))
      else $error("Out of range hour stored.");

   bcd_reject_a: assert property (
      wr_slot_s(`RHD_IDX_MONTHDAY) ##0 (!s.dm && s.wdata[3:0] >
      `RHD_BCD_DIGIT_MAX) |=> $stable(s.regs[3]) && s.rej)
      else $error("Bad BCD digit stored.");

   bin_mode_a: assert property (
      wr_slot_s(`RHD_IDX_MONTH) ##0 (s.dm && s.wdata == 8'h0C)
      |=> s.regs[4] == 8'h0C)
      else $error("Binary month refused.");

   hour_compare_a: assert property (
      s.regs[1][7:6] != `RHD_WILDCARD |->
      s.match == (s.regs[1] == s.regs[0]))
      else $error("Hour match wrong.");

   wildcard_match_a: assert property (
      s.regs[1][7:6] == `RHD_WILDCARD |-> s.match && hour_alarm_match)
      else $error("Wildcard did not match.");

   weekday_mode_a: assert property (
      wr_slot_s(`RHD_IDX_WEEKDAY) ##0 (s.wdata == `RHD_WEEKDAY_MAX)
      |=> s.regs[2] == `RHD_WEEKDAY_MAX)
      else $error("Weekday write lost.");

   weekday_range_a: assert property (
      wr_slot_s(`RHD_IDX_WEEKDAY) ##0 (s.wdata > `RHD_WEEKDAY_MAX)
      |=> $stable(s.regs[2]))
      else $error("Weekday out of range.");

   mday_range_a: assert property (
      wr_slot_s(`RHD_IDX_MONTHDAY) ##0 (s.dm && s.wdata[6:0] >
      `RHD_MDAY_MAX) |=> $stable(s.regs[3]))
      else $error("Monthday_count out of range.");

   month_range_a: assert property (
      wr_slot_s(`RHD_IDX_MONTH) ##0 (s.dm && s.wdata[6:0] >
      `RHD_MONTH_MAX) |=> $stable(s.regs[4]))
      else $error("Month out of range.");

   year_range_a: assert property (
      wr_slot_s(`RHD_IDX_YEAR) ##0 (s.dm && s.wdata[6:0] >
      `RHD_YEAR_MAX) |=> $stable(s.regs[5]))
      else $error("Year out of range.");

   sequence rd_taken_s;
      s_axi_arvalid && s.arready;
   endsequence

   sequence wr_bad_s;
      commit && s.wlane && s.aw_idx >= `RHD_IDX_HOUR &&
      s.aw_idx <= `RHD_IDX_YEAR && !val_ok;
   endsequence

   sequence wr_ctrl_s;
      commit && s.wlane && s.aw_idx == `RHD_IDX_CTRL;
   endsequence

   read_resp_a: assert property (rd_taken_s |=> s.rvalid && !s.arready)
      else $error("Read response late.");

   reject_keep_a: assert property (
      wr_bad_s |=> s.rej && $stable(s.regs))
      else $error("Refused write changed a register.");

   lane_off_a: assert property (
      commit && !s.wlane |=> $stable(s.regs) && $stable(s.dm))
      else $error("Write without lane changed state.");

   unmapped_err_a: assert property (
      commit && s.aw_idx < `RHD_IDX_HOUR
      |=> s.bvalid && s.bresp == `RHD_RESP_SLVERR)
      else $error("Unmapped write not refused.");

   ready_release_a: assert property (
      $rose(aresetn) |=> s.awready && s.wready && s.arready)
      else $error("Bus not ready after reset.");

   h24_write_a: assert property (
      wr_ctrl_s ##0 s.wdata[`RHD_CTRL_H24_BIT]
      |=> s.h24 && !s.regs[0][`RHD_PM_BIT])
      else $error("24-hour select left PM flag set.");

   dm_write_a: assert property (
      wr_ctrl_s |=> s.dm == $past(s.wdata[`RHD_CTRL_DM_BIT]))
      else $error("Data-mode bit not stored.");

   hour24_store_a: assert property (
      wr_hour_s ##0 (s.dm && s.h24 && s.wdata == 8'h17)
      |=> s.regs[0] == 8'h17)
      else $error("Last 24-hour value refused.");

   bcd_year_a: assert property (
      wr_slot_s(`RHD_IDX_YEAR) ##0 (!s.dm && s.wdata == 8'h99)
      |=> s.regs[5] == 8'h99)
      else $error("BCD year 99 refused.");

   reset_clear_a: assert property (
      disable iff (1'b0) !aresetn |=> s.regs == '0 && !s.bvalid)
      else $error("Registers not cleared by reset.");

endmodule // rhd_regs

/* File: verif/test_rtc_hour_date_registers.sv */
`timescale 1ns/1ns
`include "rhd_defs.svh"

// ****************************************************************
// Bench for the hour and date registers.
// ****************************************************************
module test_rtc_hour_date_registers;
   import rhd_pkg::*;
   logic        aclk, aresetn;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [2:0]  s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, hour_alarm_match;
   logic        data_format_select, hour_format_24, ok_seen;
   rhd_resp_t   s_axi_bresp, s_axi_rresp, resp;
   logic [7:0]  shadow [4:9];
   int          miscompares, comparisons;

   rhd_regs u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .hour_alarm_match, .data_format_select,
      .hour_format_24);

   // ****************************************************************
   // Bus tasks and comparisons.
   // ****************************************************************
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: expected %h got %h", $time, exp, got);
      end
   endtask

   task automatic wr(input logic [5:0] idx, input logic [7:0] val);
      bit aw, w;
      int n;
      aw = 0;
      w = 0;
      n = 0;
      s_axi_awaddr  <= {idx, 2'b00};
      s_axi_wdata   <= {24'h00_0000, val};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      while (!(aw && w) && n < 100) begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) begin
            aw = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do begin
         @(posedge aclk);
         n++;
      end while (s_axi_bvalid !== 1'b1 && n < 100);
      resp = s_axi_bresp;
      if (n >= 100) miscompares++;
   endtask

   task automatic rdr(input logic [5:0] idx);
      int n;
      n = 0;
      s_axi_araddr  <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
      end while (s_axi_arready !== 1'b1 && n < 100);
      s_axi_arvalid <= 1'b0;
      do begin
         @(posedge aclk);
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 100);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      if (n >= 100) miscompares++;
   endtask

   task automatic check_all;
      logic m;
      m = shadow[5][7:6] == `RHD_WILDCARD || shadow[5] == shadow[4];
      for (int i = 4; i <= 9; i++) begin
         rdr(6'(i));
         chk({24'h00_0000, shadow[i]}, rd);
      end
      chk(32'(m), 32'(hour_alarm_match));
      rdr(`RHD_IDX_STAT);
      chk(32'(m), 32'(rd[`RHD_STAT_MATCH_BIT]));
   endtask

   task automatic wr_chk(input logic [5:0] idx, input logic [7:0] val,
                         input bit ok);
      wr(idx, val);
      chk(32'(`RHD_RESP_OKAY), 32'(resp));
      if (ok) shadow[idx] = val;
      check_all();
      chk(32'(!ok), 32'(rd[`RHD_STAT_REJ_BIT]));
   endtask

   task automatic reset_dut;
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      for (int i = 4; i <= 9; i++) shadow[i] = 8'h00;
   endtask

   task automatic report_and_stop;
      $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ****************************************************************
   // Clock, watchdog and test sequence.
   // ****************************************************************
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      report_and_stop();
   end

   initial begin
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awprot, s_axi_arprot} = '0;
      s_axi_wstrb = 4'h1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      miscompares = 0;
      comparisons = 0;
      reset_dut();
      check_all();
      chk(32'h0000_0000, 32'(data_format_select));
      wr_chk(6'h04, 8'h92, 1);
      wr_chk(6'h04, 8'h13, 0);
      wr_chk(6'h04, 8'h00, 0);
      wr_chk(6'h04, 8'h0A, 0);
      wr_chk(6'h05, 8'h91, 1);
      wr_chk(6'h05, 8'h92, 1);
      wr_chk(6'h05, 8'hC3, 1);
      wr_chk(6'h06, 8'h07, 1);
      wr_chk(6'h06, 8'h08, 0);
      wr_chk(6'h07, 8'h31, 1);
      wr_chk(6'h07, 8'h32, 0);
      wr_chk(6'h07, 8'h1A, 0);
      wr_chk(6'h08, 8'h12, 1);
      wr_chk(6'h08, 8'h13, 0);
      wr_chk(6'h09, 8'h99, 1);
      wr_chk(6'h09, 8'h9A, 0);
      wr(`RHD_IDX_CTRL, 8'h04);
      chk(32'(`RHD_RESP_OKAY), 32'(resp));
      chk(32'h0000_0001, 32'(data_format_select));
      wr_chk(6'h06, 8'h05, 1);
      wr_chk(6'h06, 8'h00, 0);
      wr_chk(6'h07, 8'h1F, 1);
      wr_chk(6'h07, 8'h20, 0);
      wr_chk(6'h08, 8'h0C, 1);
      wr_chk(6'h08, 8'h12, 0);
      wr_chk(6'h09, 8'h63, 1);
      wr_chk(6'h09, 8'h64, 0);
      wr_chk(6'h05, 8'h8C, 1);
      wr_chk(6'h04, 8'h8C, 1);
      wr_chk(6'h04, 8'h0D, 0);
      s_axi_wstrb <= 4'h0;
      wr(6'h06, 8'h03);
      s_axi_wstrb <= 4'h1;
      chk(32'(`RHD_RESP_OKAY), 32'(resp));
      check_all();
      wr(`RHD_IDX_CTRL, 8'h06);
      chk(32'(`RHD_RESP_OKAY), 32'(resp));
      chk(32'h0000_0001, 32'(hour_format_24));
      rdr(`RHD_IDX_CTRL);
      chk(32'h0000_0006, rd);
      shadow[4][`RHD_PM_BIT] = 1'b0;
      shadow[5][`RHD_PM_BIT] = 1'b0;
      check_all();
      wr_chk(6'h04, 8'h17, 1);
      wr_chk(6'h04, 8'h18, 0);
      wr_chk(6'h04, 8'h97, 0);
      wr_chk(6'h04, 8'h00, 1);
      wr_chk(6'h05, 8'hC0, 1);
      wr(6'h03, 8'h55);
      chk(32'(`RHD_RESP_SLVERR), 32'(resp));
      rdr(6'h03);
      chk(32'(`RHD_RESP_SLVERR), 32'(resp));
      chk(32'h0000_0000, rd);
      reset_dut();
      check_all();
      chk(32'h0000_0000, 32'(hour_format_24));
      chk(32'h0000_0000, 32'(data_format_select));
      report_and_stop();
   end
endmodule // test_rtc_hour_date_registers
